/* File: design/counter_event_trigger_params.svh */
`ifndef COUNTER_EVENT_TRIGGER_PARAMS_SVH
`define COUNTER_EVENT_TRIGGER_PARAMS_SVH

`define CET_ASSOC_C0 8'h00
`define CET_ASSOC_C1 8'h01
`define CET_ASSOC_NONE 8'hff
`define CET_SEQ_FIRST 32'h00000001
`define CET_SEQ_RESET 32'h00000000
`define CET_NUM_FUNCS 7
`define CET_F_ZERO 0
`define CET_F_SUSPEND 1
`define CET_F_PRESET 2
`define CET_F_CAPTURE 3
`define CET_F_UPPER 4
`define CET_F_LOWER 5
`define CET_F_SENSE 6

`endif

/* File: design/counter_event_trigger_pkg.sv */
package counter_event_trigger_pkg;
  typedef logic [31:0] seq_t;
  typedef enum {ASSOC_C0, ASSOC_C1, ASSOC_NONE} assoc_t;
endpackage

/* File: design/counter_event_trigger.sv */
`timescale 1ns/1ps
`default_nettype none
`include "counter_event_trigger_params.svh"

module counter_event_trigger #(
  parameter int NUM_WINDOWS = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // trigger definition from the controller
  input wire logic triggerDefinitionActive,
  input wire logic fireOnMatchEdge,
  input wire logic fireOnUnmatchEdge,
  input wire logic holdUntilAcknowledged,
  input wire logic anyConditionFires,
  input wire logic [7:0] counterAssociation,
  input wire logic [31:0] receiptSequence,
  input wire logic [NUM_WINDOWS-1:0] windowParticipation,
  input wire logic [NUM_WINDOWS-1:0] windowMatchValue,
  input wire logic zeroingParticipation,
  input wire logic suspendParticipation,
  input wire logic presetParticipation,
  input wire logic captureParticipation,
  input wire logic upperWrapParticipation,
  input wire logic lowerWrapParticipation,
  input wire logic countSenseParticipation,
  input wire logic [`CET_NUM_FUNCS-1:0] functionMatchValue,
  // counter and window state, two counters
  input wire logic [1:0] cntZeroing,
  input wire logic [1:0] cntSuspend,
  input wire logic [1:0] cntPreset,
  input wire logic [1:0] cntCapture,
  input wire logic [1:0] cntUpperWrap,
  input wire logic [1:0] cntLowerWrap,
  input wire logic [1:0] cntCountDown,
  input wire logic [NUM_WINDOWS-1:0] inWindow,
  // counter input pins, asynchronous
  input wire logic pinA,
  input wire logic pinB,
  input wire logic pinZ,
  // event record
  output logic eventPending,
  output logic eventPulse,
  output logic eventLost,
  output logic [31:0] firedSequence,
  output logic zeroingStateFlag,
  output logic recordCountDown,
  output logic [2:0] recordAbz,
  output logic [NUM_WINDOWS-1:0] recordInWindow
);

  function automatic counter_event_trigger_pkg::assoc_t decodeAssoc(input logic [7:0] code);
    if (code == `CET_ASSOC_C0) begin
      return counter_event_trigger_pkg::ASSOC_C0;
    end else if (code == `CET_ASSOC_C1) begin
      return counter_event_trigger_pkg::ASSOC_C1;
    end else begin
      return counter_event_trigger_pkg::ASSOC_NONE;
    end
  endfunction

  // wrap-safe: ack covers seq when ack is at or past it
  function automatic logic seqCovered(input logic [31:0] ack, input logic [31:0] seq);
    logic [31:0] diff;
    diff = ack - seq;
    return ~diff[31];
  endfunction

  // pin synchroniser
  logic [2:0] abzMeta_reg;
  logic [2:0] abzSync_reg;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      abzMeta_reg <= 3'h0;
      abzSync_reg <= 3'h0;
    end else begin
      abzMeta_reg <= {pinZ, pinB, pinA};
      abzSync_reg <= abzMeta_reg;
    end
  end

  counter_event_trigger_pkg::assoc_t assoc;
  logic useC1;
  logic [`CET_NUM_FUNCS-1:0] funcState;
  logic [`CET_NUM_FUNCS-1:0] funcSelect;
  logic [`CET_NUM_FUNCS-1:0] funcHit;
  logic [NUM_WINDOWS-1:0] winHit;
  logic anySelected;
  logic allMet;
  logic anyMet;
  logic matchNow;

  always_comb begin
    assoc = decodeAssoc(counterAssociation);
    useC1 = (assoc == counter_event_trigger_pkg::ASSOC_C1);
    funcState = '0;
    if (assoc != counter_event_trigger_pkg::ASSOC_NONE) begin
      funcState[`CET_F_ZERO] = cntZeroing[useC1];
      funcState[`CET_F_SUSPEND] = cntSuspend[useC1];
      funcState[`CET_F_PRESET] = cntPreset[useC1];
      funcState[`CET_F_CAPTURE] = cntCapture[useC1];
      funcState[`CET_F_UPPER] = cntUpperWrap[useC1];
      funcState[`CET_F_LOWER] = cntLowerWrap[useC1];
      funcState[`CET_F_SENSE] = cntCountDown[useC1];
    end
    funcSelect = '0;
    // an unassociated event has no counter to watch
    if (assoc != counter_event_trigger_pkg::ASSOC_NONE) begin
      funcSelect[`CET_F_ZERO] = zeroingParticipation;
      funcSelect[`CET_F_SUSPEND] = suspendParticipation;
      funcSelect[`CET_F_PRESET] = presetParticipation;
      funcSelect[`CET_F_CAPTURE] = captureParticipation;
      funcSelect[`CET_F_UPPER] = upperWrapParticipation;
      funcSelect[`CET_F_LOWER] = lowerWrapParticipation;
      funcSelect[`CET_F_SENSE] = countSenseParticipation;
    end
    funcHit = ~(funcState ^ functionMatchValue);
    winHit = ~(inWindow ^ windowMatchValue);
    anySelected = (|funcSelect) | (|windowParticipation);
    allMet = (&(funcHit | ~funcSelect)) & (&(winHit | ~windowParticipation));
    anyMet = (|(funcHit & funcSelect)) | (|(winHit & windowParticipation));
    matchNow = triggerDefinitionActive & anySelected
      & (anyConditionFires ? anyMet : allMet);
  end

  logic matchPrev_reg;
  logic matchPrev_next;
  logic fire;
  logic acked;
  logic store;
  logic [31:0] seqCount_reg;
  logic [31:0] seqCount_next;
  logic pending_reg;
  logic pending_next;
  logic pulse_reg;
  logic pulse_next;
  logic lost_reg;
  logic lost_next;
  logic [31:0] recSeq_reg;
  logic [31:0] recSeq_next;
  logic recZero_reg;
  logic recZero_next;
  logic recDown_reg;
  logic recDown_next;
  logic [2:0] recAbz_reg;
  logic [2:0] recAbz_next;
  logic [NUM_WINDOWS-1:0] recWin_reg;
  logic [NUM_WINDOWS-1:0] recWin_next;

  always_comb begin
    matchPrev_next = matchNow;
    // edges only, so a steady match raises nothing more
    fire = triggerDefinitionActive
      & ((fireOnMatchEdge & matchNow & ~matchPrev_reg)
      | (fireOnUnmatchEdge & ~matchNow & matchPrev_reg));
    acked = seqCovered(receiptSequence, recSeq_reg);
    store = fire & ~(holdUntilAcknowledged & pending_reg & ~acked);
    seqCount_next = fire ? seqCount_reg + `CET_SEQ_FIRST : seqCount_reg;
    pulse_next = store;
    lost_next = fire & ~store;
    // a new record wins over a same-cycle acknowledge
    pending_next = store | (pending_reg & ~acked);
    recSeq_next = recSeq_reg;
    recZero_next = recZero_reg;
    recDown_next = recDown_reg;
    recAbz_next = recAbz_reg;
    recWin_next = recWin_reg;
    if (store) begin
      recSeq_next = seqCount_reg;
      recZero_next = funcState[`CET_F_ZERO];
      recDown_next = funcState[`CET_F_SENSE];
      recAbz_next = abzSync_reg;
      recWin_next = inWindow;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      matchPrev_reg <= 1'b0;
      seqCount_reg <= `CET_SEQ_FIRST;
      pending_reg <= 1'b0;
      pulse_reg <= 1'b0;
      lost_reg <= 1'b0;
      recSeq_reg <= `CET_SEQ_RESET;
      recZero_reg <= 1'b0;
      recDown_reg <= 1'b0;
      recAbz_reg <= 3'h0;
      recWin_reg <= '0;
    end else begin
      matchPrev_reg <= matchPrev_next;
      seqCount_reg <= seqCount_next;
      pending_reg <= pending_next;
      pulse_reg <= pulse_next;
      lost_reg <= lost_next;
      recSeq_reg <= recSeq_next;
      recZero_reg <= recZero_next;
      recDown_reg <= recDown_next;
      recAbz_reg <= recAbz_next;
      recWin_reg <= recWin_next;
    end
  end

  assign eventPending = pending_reg;
  assign eventPulse = pulse_reg;
  assign eventLost = lost_reg;
  assign firedSequence = recSeq_reg;
  assign zeroingStateFlag = recZero_reg;
  assign recordCountDown = recDown_reg;
  assign recordAbz = recAbz_reg;
  assign recordInWindow = recWin_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // independent view of the selections, kept apart from the datapath
  logic assocValid;
  logic [`CET_NUM_FUNCS-1:0] chkSel;
  logic [`CET_NUM_FUNCS-1:0] chkState;
  assign assocValid = (counterAssociation == `CET_ASSOC_C0)
    | (counterAssociation == `CET_ASSOC_C1);
  assign chkSel = {countSenseParticipation, lowerWrapParticipation, upperWrapParticipation,
    captureParticipation, presetParticipation, suspendParticipation, zeroingParticipation};
  assign chkState = (counterAssociation == `CET_ASSOC_C1)
    ? {cntCountDown[1], cntLowerWrap[1], cntUpperWrap[1], cntCapture[1],
      cntPreset[1], cntSuspend[1], cntZeroing[1]}
    : {cntCountDown[0], cntLowerWrap[0], cntUpperWrap[0], cntCapture[0],
      cntPreset[0], cntSuspend[0], cntZeroing[0]};

  AST_ZERO_BLOCKS: assert property (
    !anyConditionFires && assocValid && chkSel[`CET_F_ZERO]
    && chkState[`CET_F_ZERO] != functionMatchValue[`CET_F_ZERO] |-> !matchNow)
    else $error("unmet zeroing condition matched");
  AST_ZERO_ALONE: assert property (
    triggerDefinitionActive && anyConditionFires && assocValid && chkSel[`CET_F_ZERO]
    && chkState[`CET_F_ZERO] == functionMatchValue[`CET_F_ZERO] |-> matchNow)
    else $error("met zeroing condition ignored");
  AST_SUSPEND_BLOCKS: assert property (
    !anyConditionFires && assocValid && chkSel[`CET_F_SUSPEND]
    && chkState[`CET_F_SUSPEND] != functionMatchValue[`CET_F_SUSPEND] |-> !matchNow)
    else $error("unmet suspend condition matched");
  AST_SUSPEND_ALONE: assert property (
    triggerDefinitionActive && anyConditionFires && assocValid && chkSel[`CET_F_SUSPEND]
    && chkState[`CET_F_SUSPEND] == functionMatchValue[`CET_F_SUSPEND] |-> matchNow)
    else $error("met suspend condition ignored");
  AST_PRESET_BLOCKS: assert property (
    !anyConditionFires && assocValid && chkSel[`CET_F_PRESET]
    && chkState[`CET_F_PRESET] != functionMatchValue[`CET_F_PRESET] |-> !matchNow)
    else $error("unmet preset condition matched");
  AST_PRESET_ALONE: assert property (
    triggerDefinitionActive && anyConditionFires && assocValid && chkSel[`CET_F_PRESET]
    && chkState[`CET_F_PRESET] == functionMatchValue[`CET_F_PRESET] |-> matchNow)
    else $error("met preset condition ignored");
  AST_CAPTURE_BLOCKS: assert property (
    !anyConditionFires && assocValid && chkSel[`CET_F_CAPTURE]
    && chkState[`CET_F_CAPTURE] != functionMatchValue[`CET_F_CAPTURE] |-> !matchNow)
    else $error("unmet capture condition matched");
  AST_CAPTURE_ALONE: assert property (
    triggerDefinitionActive && anyConditionFires && assocValid && chkSel[`CET_F_CAPTURE]
    && chkState[`CET_F_CAPTURE] == functionMatchValue[`CET_F_CAPTURE] |-> matchNow)
    else $error("met capture condition ignored");
  AST_UPPER_BLOCKS: assert property (
    !anyConditionFires && assocValid && chkSel[`CET_F_UPPER]
    && chkState[`CET_F_UPPER] != functionMatchValue[`CET_F_UPPER] |-> !matchNow)
    else $error("unmet upper wrap condition matched");
  AST_UPPER_ALONE: assert property (
    triggerDefinitionActive && anyConditionFires && assocValid && chkSel[`CET_F_UPPER]
    && chkState[`CET_F_UPPER] == functionMatchValue[`CET_F_UPPER] |-> matchNow)
    else $error("met upper wrap condition ignored");
  AST_LOWER_BLOCKS: assert property (
    !anyConditionFires && assocValid && chkSel[`CET_F_LOWER]
    && chkState[`CET_F_LOWER] != functionMatchValue[`CET_F_LOWER] |-> !matchNow)
    else $error("unmet lower wrap condition matched");
  AST_LOWER_ALONE: assert property (
    triggerDefinitionActive && anyConditionFires && assocValid && chkSel[`CET_F_LOWER]
    && chkState[`CET_F_LOWER] == functionMatchValue[`CET_F_LOWER] |-> matchNow)
    else $error("met lower wrap condition ignored");
  AST_SENSE_BLOCKS: assert property (
    !anyConditionFires && assocValid && chkSel[`CET_F_SENSE]
    && chkState[`CET_F_SENSE] != functionMatchValue[`CET_F_SENSE] |-> !matchNow)
    else $error("unmet direction condition matched");
  AST_SENSE_ALONE: assert property (
    triggerDefinitionActive && anyConditionFires && assocValid && chkSel[`CET_F_SENSE]
    && chkState[`CET_F_SENSE] == functionMatchValue[`CET_F_SENSE] |-> matchNow)
    else $error("met direction condition ignored");
  AST_WIN_BLOCKS: assert property (
    !anyConditionFires && |(windowParticipation & (inWindow ^ windowMatchValue))
    |-> !matchNow)
    else $error("unmet window condition matched");
  AST_WIN_ALONE: assert property (
    triggerDefinitionActive && anyConditionFires
    && |(windowParticipation & ~(inWindow ^ windowMatchValue)) |-> matchNow)
    else $error("met window condition ignored");
  AST_INACTIVE_NO_MATCH: assert property (
    !triggerDefinitionActive |-> !matchNow)
    else $error("inactive definition matched");
  AST_NONE_SELECTED: assert property (
    chkSel == '0 && windowParticipation == '0 |-> !matchNow)
    else $error("empty definition matched");
  AST_PULSE_XOR_LOST: assert property (
    !(eventPulse && eventLost))
    else $error("event both stored and lost");
  AST_LOST_ONLY_LATCHED: assert property (
    eventLost |-> $past(holdUntilAcknowledged))
    else $error("event lost while not latching");
  AST_PENDING_SET: assert property (
    store |=> eventPending)
    else $error("stored record not pending");
  AST_ACK_KEEPS: assert property (
    eventPending && !acked |=> eventPending)
    else $error("record retired without acknowledge");
  AST_RECORD_STABLE: assert property (
    !store |=> $stable(firedSequence) && $stable(zeroingStateFlag) && $stable(recordAbz))
    else $error("record changed without store");
  AST_WIN_CAPTURE: assert property (
    store |=> recordInWindow == $past(inWindow))
    else $error("window levels not captured");
  AST_DIR_CAPTURE: assert property (
    store && assocValid |=> recordCountDown == $past(chkState[`CET_F_SENSE]))
    else $error("direction not captured");
  AST_SEQ_HOLD: assert property (
    !fire |=> $stable(seqCount_reg))
    else $error("sequence moved without event");

  AST_INACTIVE_SILENT: assert property (
    !triggerDefinitionActive |=> !eventPulse && !eventLost)
    else $error("inactive definition raised an event");
  AST_STEADY_ONCE: assert property (
    matchNow && matchPrev_reg |-> !fire)
    else $error("steady match fired again");
  AST_MATCH_EDGE: assert property (
    triggerDefinitionActive && fireOnMatchEdge && matchNow && !matchPrev_reg
    |=> eventPulse || eventLost)
    else $error("match edge did not fire");
  AST_UNMATCH_EDGE: assert property (
    triggerDefinitionActive && fireOnUnmatchEdge && !matchNow && matchPrev_reg
    |=> eventPulse || eventLost)
    else $error("unmatch edge did not fire");
  AST_LATCH_HOLDS: assert property (
    holdUntilAcknowledged && eventPending && !acked && fire
    |=> eventLost && $stable(firedSequence))
    else $error("latched record was replaced");
  AST_OVERWRITE: assert property (
    !holdUntilAcknowledged && fire |=> eventPulse && firedSequence == $past(seqCount_reg))
    else $error("record not overwritten");
  AST_ZERO_FLAG: assert property (
    store |=> zeroingStateFlag == $past(funcState[`CET_F_ZERO]))
    else $error("zeroing flag wrong");
  AST_NO_COUNTER: assert property (
    counterAssociation == `CET_ASSOC_NONE && windowParticipation == '0 |-> !matchNow)
    else $error("unassociated event matched");
  AST_ACK_RETIRES: assert property (
    eventPending && acked && !store |=> !eventPending)
    else $error("acknowledge did not retire record");
  AST_SEQ_STEP: assert property (
    fire |=> seqCount_reg == $past(seqCount_reg) + `CET_SEQ_FIRST)
    else $error("sequence did not advance");
  AST_ABZ_CAPTURE: assert property (
    store |=> recordAbz == $past(abzSync_reg))
    else $error("pin levels not captured");

  COV_FIRE: cover property (eventPulse);
  COV_LOST: cover property (eventLost);
  COV_ACK: cover property (eventPending ##1 !eventPending);
  COV_OR_MODE: cover property (anyConditionFires && fire);
  COV_LATCH_DROP: cover property (holdUntilAcknowledged && eventLost);

endmodule
`default_nettype wire

/* File: testbench/ack_controller.sv */
`timescale 1ns/1ps
`default_nettype none

module ack_controller (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // bench control
  input wire logic ackEn,
  input wire logic [3:0] ackDelay,
  // record from the device
  input wire logic eventPending,
  input wire logic [31:0] firedSequence,
  // acknowledge to the device
  output logic [31:0] receiptSequence
);
  logic [3:0] waitCnt;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      receiptSequence <= 32'h00000000;
      waitCnt <= 4'h0;
    end else if (ackEn && eventPending) begin
      // slow controller: answers only after ackDelay cycles
      if (waitCnt >= ackDelay) begin
        receiptSequence <= firedSequence;
        waitCnt <= 4'h0;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end else begin
      waitCnt <= 4'h0;
    end
  end
endmodule

`default_nettype wire

/* File: testbench/tb_counter_event_trigger.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_counter_event_trigger;
  logic ref_clk, reset_n, active, onMatch, onUnmatch, latch, anyCond, ackEn;
  logic pinA, pinB, pinZ, eventPending, eventPulse, eventLost, zeroingStateFlag, recordCountDown;
  logic [7:0] assoc, winSel, winVal, inWin, recordInWindow;
  logic [6:0] sel, funcVal;
  logic [1:0] cnt [7];
  logic [3:0] ackDelay;
  logic [31:0] receiptSequence, firedSequence, seqMark;
  logic [2:0] recordAbz;
  int n_mismatch = 0, checks = 0, nPulse = 0, nLost = 0;

  counter_event_trigger dut_u (.ref_clk(ref_clk),
    .reset_n(reset_n), .triggerDefinitionActive(active), .fireOnMatchEdge(onMatch),
    .fireOnUnmatchEdge(onUnmatch), .holdUntilAcknowledged(latch), .anyConditionFires(anyCond),
    .counterAssociation(assoc), .receiptSequence(receiptSequence),
    .windowParticipation(winSel), .windowMatchValue(winVal), .zeroingParticipation(sel[0]),
    .suspendParticipation(sel[1]), .presetParticipation(sel[2]), .captureParticipation(sel[3]),
    .upperWrapParticipation(sel[4]), .lowerWrapParticipation(sel[5]),
    .countSenseParticipation(sel[6]), .functionMatchValue(funcVal), .cntZeroing(cnt[0]),
    .cntSuspend(cnt[1]), .cntPreset(cnt[2]), .cntCapture(cnt[3]), .cntUpperWrap(cnt[4]),
    .cntLowerWrap(cnt[5]), .cntCountDown(cnt[6]), .inWindow(inWin), .pinA(pinA), .pinB(pinB),
    .pinZ(pinZ), .eventPending(eventPending), .eventPulse(eventPulse), .eventLost(eventLost),
    .firedSequence(firedSequence), .zeroingStateFlag(zeroingStateFlag),
    .recordCountDown(recordCountDown), .recordAbz(recordAbz), .recordInWindow(recordInWindow));

  ack_controller ctrl_u (.ref_clk(ref_clk), .reset_n(reset_n), .ackEn(ackEn),
    .ackDelay(ackDelay), .eventPending(eventPending), .firedSequence(firedSequence),
    .receiptSequence(receiptSequence));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // pulses are one cycle wide, so count them mid-cycle where they are settled
  always @(negedge ref_clk) begin
    if (eventPulse === 1'b1) nPulse++;
    if (eventLost === 1'b1) nLost++;
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task t_edges;
    winSel = 8'h01; winVal = 8'h01; inWin = 8'h01; tick(4);
    check("inactive pulses", nPulse, 0);
    inWin = 8'h00; active = 1'b1; onMatch = 1'b1; tick(2); inWin = 8'h01; tick(6);
    check("match pulses", nPulse, 1);
    inWin = 8'h00; tick(3); check("no unmatch pulse", nPulse, 1);
    onUnmatch = 1'b1; inWin = 8'h01; tick(3); inWin = 8'h00; tick(3);
    check("both edges", nPulse, 3);
    check("sequence", firedSequence, 32'h00000003);
  endtask

  task t_and_or;
    nPulse = 0; onUnmatch = 1'b0; winSel = 8'h03; winVal = 8'h03; inWin = 8'h01; tick(4);
    check("and partial", nPulse, 0);
    inWin = 8'h00; anyCond = 1'b1; tick(2); inWin = 8'h02; tick(3);
    check("or single", nPulse, 1);
    check("window record", recordInWindow, 8'h02);
    inWin = 8'h00; anyCond = 1'b0; winSel = 8'h00; assoc = 8'h01; tick(2);
  endtask

  task t_funcs;
    for (int f = 0; f < 7; f++) begin
      nPulse = 0; sel = 7'h01 << f; funcVal = 7'h01 << f; cnt[f] = 2'b01; tick(4);
      check("other counter", nPulse, 0);
      cnt[f] = 2'b11; tick(3);
      check("function match", nPulse, 1);
      if (f == 0) check("zeroing flag", zeroingStateFlag, 1'b1);
      if (f == 6) check("direction record", recordCountDown, 1'b1);
      cnt[f] = 2'b00; tick(2); funcVal = 7'h00; tick(3);
      check("zero value match", nPulse, 2);
    end
    nPulse = 0; assoc = 8'hff; sel = 7'h01; funcVal = 7'h01; cnt[0] = 2'b11; tick(4);
    check("no counter", nPulse, 0);
    sel = 7'h00; cnt[0] = 2'b00; assoc = 8'h00; winSel = 8'h01; tick(2);
  endtask

  task t_latch;
    ackEn = 1'b1; ackDelay = 4'h3; pinA = 1'b1; pinZ = 1'b1; tick(12);
    check("acked", eventPending, 1'b0);
    ackEn = 1'b0; latch = 1'b1; onUnmatch = 1'b1; nLost = 0; seqMark = firedSequence;
    inWin = 8'h01; tick(3); inWin = 8'h00; tick(3);
    check("lost", nLost, 1);
    check("kept record", firedSequence, seqMark + 32'h1);
    check("pins", recordAbz, 3'b101);
    ackEn = 1'b1; tick(8); check("released", eventPending, 1'b0);
    ackEn = 1'b0; latch = 1'b0; inWin = 8'h01; tick(3); inWin = 8'h00; tick(3);
    check("overwrite", firedSequence, seqMark + 32'h4);
  endtask

  initial begin
    #(3000 * 100);
    n_mismatch++;
    print_verdict;
  end

  initial begin
    {reset_n, active, onMatch, onUnmatch, latch, anyCond, ackEn, pinA, pinB, pinZ} = 10'h000;
    {assoc, winSel, winVal, inWin, sel, funcVal, ackDelay} = 50'h0;
    foreach (cnt[i]) cnt[i] = 2'b00;
    repeat (16) @(posedge ref_clk);
    #10 reset_n = 1'b1;
    tick(2);
    t_edges;
    t_and_or;
    t_funcs;
    t_latch;
    print_verdict;
  end
endmodule

`default_nettype wire
